// [src/sera_pkg.sv]
// Shared constants and types for the two-wire serial memory target
package sera_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SERA_WRITE_TIME_MS = 5;
  localparam int SERA_CLK_KHZ = 250_000;
  // Longest time, so the count rounds down (exact here)
  localparam int SERA_WRITE_CYCLES = SERA_WRITE_TIME_MS * SERA_CLK_KHZ;
  // ----------------------------------------------------------------
  // Protocol fields
  // ----------------------------------------------------------------
  localparam logic [3:0] SERA_DEV_CODE = 4'ha;
  localparam logic [3:0] SERA_ACK_SLOT = 4'h8;
  localparam logic [3:0] SERA_LAST_BIT = 4'h7;
  localparam int SERA_RW_BIT = 0;
  localparam int SERA_LINE_SCL = 1;
  localparam int SERA_LINE_SDA = 0;
  localparam int SERA_BASE_ADDR_W = 8;
  localparam int SERA_PAGE_SEL_W = 3;
  localparam logic [1:0] SERA_LINE_IDLE = 2'h3;

  typedef struct packed {
    logic scl;
    logic sda;
  } sera_line_t;

  typedef enum logic [2:0] {
    SERA_ST_IDLE = 3'b000,
    SERA_ST_DEV = 3'b001,
    SERA_ST_WORD = 3'b010,
    SERA_ST_WDATA = 3'b011,
    SERA_ST_RDATA = 3'b100
  } sera_state_t;
endpackage : sera_pkg

// [src/sera_eeprom_core.sv]
// Two-wire serial memory target: transfer decode, page buffer, write timer, array
//
// Contract
// RULE1: Write: word address byte follows acked device address; acked, then data accepted.
// RULE2: Each received data byte is acked; single-byte write ends with stop.
// RULE3: Stop after write starts programming; no response until programming ends.
// RULE4: Programming runs from stop to end of internal write, at most 5 ms.
// RULE5: Page holds 8 bytes on smallest variant, 16 bytes on larger ones.
// RULE6: Page write: further bytes may follow the first, each acked.
// RULE7: Write advances only low page bits of word address; wraps inside page.
// RULE8: Bytes beyond one page replace earlier bytes of that page.
// RULE9: Polling during programming is nacked; acked once programming completes.
// RULE10: Last device address bit selects read when high, write when low.
// RULE11: Each received address or data byte is acked low in ninth clock.
// RULE12: Controller starts a read like a write but with direction bit one.
// RULE13: Word address counter holds last accessed plus one across operations.
// RULE14: Read past last byte wraps counter to first byte of array.
// RULE15: After acked read address, byte at counter is shifted out.
// RULE16: Controller ends a read with no ack then a stop.
// RULE17: Random read: dummy write, repeated start, read address; data returned.
// RULE18: Each controller ack in a read increments address, next byte sent.
// RULE19: Sequential read wraps at array top and keeps sending.
// RULE20: Capacity, page size and page-select bits are build-time parameters.
`timescale 1ns/100ps
module sera_eeprom_core import sera_pkg::*; #(
  parameter int PAGE_ADDR_BITS = 0,
  parameter int PAGE_BYTES = 8,
  parameter int WRITE_CYCLES = SERA_WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] strap_select_inputs,
  output logic write_busy
);
  // ----------------------------------------------------------------
  // Sizing
  // ----------------------------------------------------------------
  localparam int ADDR_W = SERA_BASE_ADDR_W + PAGE_ADDR_BITS; // [RULE20]
  localparam int MEM_BYTES = 1 << ADDR_W;
  localparam int PAGE_W = $clog2(PAGE_BYTES); // [RULE5]
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
  localparam logic [2:0] STRAP_MASK = 3'(3'h7 << PAGE_ADDR_BITS);

  if (PAGE_ADDR_BITS < 0 || PAGE_ADDR_BITS > SERA_PAGE_SEL_W || (PAGE_BYTES != 8 && PAGE_BYTES != 16)
      || WRITE_CYCLES < 2) begin : g_bad_param
    $error("sera_eeprom_core: unsupported parameter values");
  end

  // ----------------------------------------------------------------
  // Pin sampling: three stages, accept when the last two agree
  // ----------------------------------------------------------------
  logic [1:0] s1_reg, s2_reg, s3_reg, filt_reg, prev_reg;
  wire logic [1:0] pins = {scl_in, sda_in};

  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (reset) begin
        s1_reg[i] <= 1'b1;
        s2_reg[i] <= 1'b1;
        s3_reg[i] <= 1'b1;
        filt_reg[i] <= 1'b1;
        prev_reg[i] <= 1'b1;
      end else if (clk_en) begin
        s1_reg[i] <= pins[i];
        s2_reg[i] <= s1_reg[i];
        s3_reg[i] <= s2_reg[i];
        if (s2_reg[i] == s3_reg[i]) begin
          filt_reg[i] <= s3_reg[i];
        end
        prev_reg[i] <= filt_reg[i];
      end
    end
  end

  sera_line_t cur, old;
  assign cur = sera_line_t'(filt_reg);
  assign old = sera_line_t'(prev_reg);

  logic scl_rise, scl_fall, start_ev, stop_ev;
  assign scl_rise = clk_en & cur.scl & ~old.scl;
  assign scl_fall = clk_en & ~cur.scl & old.scl;
  assign start_ev = clk_en & cur.scl & old.scl & old.sda & ~cur.sda;
  assign stop_ev = clk_en & cur.scl & old.scl & ~old.sda & cur.sda;

  // ----------------------------------------------------------------
  // Transfer state
  // ----------------------------------------------------------------
  sera_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, out_reg;
  logic rw_reg, mack_reg, sda_oe_reg;
  logic [2:0] page_hi_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [CNT_W-1:0] wr_cnt_reg;
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_valid_reg;
  logic [ADDR_W-PAGE_W-1:0] page_base_reg;

  logic busy, ack_entry, ack_exit, dev_match;
  logic [10:0] word_load;
  logic [7:0] rd_byte;
  assign busy = wr_cnt_reg != '0;
  assign ack_entry = scl_fall && bit_cnt_reg == SERA_LAST_BIT;
  assign ack_exit = scl_fall && bit_cnt_reg == SERA_ACK_SLOT;
  // Strap bits compare only where they are not page-select bits
  assign dev_match = shift_reg[7:4] == SERA_DEV_CODE
                     && ((shift_reg[3:1] ^ strap_select_inputs) & STRAP_MASK) == 3'h0;
  assign word_load = {page_hi_reg, shift_reg};
  assign rd_byte = mem[addr_reg];

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= SERA_ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      out_reg <= 8'h00;
      rw_reg <= 1'b0;
      mack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      page_hi_reg <= 3'h0;
      // Reset stands for power-up, the only time the counter may lose its value
      addr_reg <= '0;
    end else if (start_ev) begin
      state_reg <= SERA_ST_DEV;
      // The clock fall that closes a start is no data bit: the count wraps to zero on it
      bit_cnt_reg <= 4'hf;
      sda_oe_reg <= 1'b0;
    end else if (stop_ev) begin
      state_reg <= SERA_ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (state_reg != SERA_ST_IDLE) begin
      if (scl_rise) begin
        if (bit_cnt_reg != SERA_ACK_SLOT) begin
          shift_reg <= {shift_reg[6:0], cur.sda};
        end else begin
          mack_reg <= ~cur.sda; // [RULE18]
        end
      end
      if (scl_fall) begin
        bit_cnt_reg <= (bit_cnt_reg == SERA_ACK_SLOT) ? 4'h0 : bit_cnt_reg + 4'h1;
      end
      if (ack_entry) begin
        case (state_reg)
          SERA_ST_DEV: begin
            // While programming, the address is heard but never acked
            if (dev_match && !busy) begin // [RULE3] [RULE9]
              sda_oe_reg <= 1'b1; // [RULE11]
              rw_reg <= shift_reg[SERA_RW_BIT]; // [RULE10] [RULE12]
              page_hi_reg <= shift_reg[3:1] & ~STRAP_MASK;
            end else begin
              state_reg <= SERA_ST_IDLE;
            end
          end
          SERA_ST_WORD: sda_oe_reg <= 1'b1; // [RULE1] [RULE11]
          SERA_ST_WDATA: begin
            sda_oe_reg <= 1'b1; // [RULE2] [RULE6]
            // Only the in-page bits move; upper bits keep the row
            addr_reg[PAGE_W-1:0] <= addr_reg[PAGE_W-1:0] + 1'b1; // [RULE7] [RULE13]
          end
          SERA_ST_RDATA: sda_oe_reg <= 1'b0;
          default: state_reg <= SERA_ST_IDLE;
        endcase
      end else if (ack_exit) begin
        case (state_reg)
          SERA_ST_DEV: begin
            if (rw_reg) begin
              state_reg <= SERA_ST_RDATA; // [RULE15] [RULE17]
              out_reg <= rd_byte;
              sda_oe_reg <= ~rd_byte[7];
              addr_reg <= addr_reg + 1'b1; // [RULE13] [RULE14]
            end else begin
              state_reg <= SERA_ST_WORD;
              sda_oe_reg <= 1'b0;
            end
          end
          SERA_ST_WORD: begin
            state_reg <= SERA_ST_WDATA;
            addr_reg <= word_load[ADDR_W-1:0]; // [RULE1] [RULE17]
            sda_oe_reg <= 1'b0;
          end
          SERA_ST_WDATA: sda_oe_reg <= 1'b0;
          SERA_ST_RDATA: begin
            if (mack_reg) begin
              out_reg <= rd_byte; // [RULE18]
              sda_oe_reg <= ~rd_byte[7];
              addr_reg <= addr_reg + 1'b1; // [RULE14] [RULE19]
            end else begin
              // No ack from the controller: release and wait for stop
              state_reg <= SERA_ST_IDLE; // [RULE16]
              sda_oe_reg <= 1'b0;
            end
          end
          default: state_reg <= SERA_ST_IDLE;
        endcase
      end else if (scl_fall && state_reg == SERA_ST_RDATA) begin
        sda_oe_reg <= ~out_reg[6];
        out_reg <= {out_reg[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Write timer: loaded on stop after received data
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_cnt_reg <= '0;
    end else if (clk_en) begin
      if (busy) begin
        wr_cnt_reg <= wr_cnt_reg - 1'b1; // [RULE4]
      end else if (stop_ev && state_reg == SERA_ST_WDATA && page_valid_reg != '0) begin
        wr_cnt_reg <= CNT_W'(WRITE_CYCLES); // [RULE3] [RULE4]
      end
    end
  end

  // ----------------------------------------------------------------
  // Page buffer and array commit
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      page_valid_reg <= '0;
      page_base_reg <= '0;
    end else if (clk_en) begin
      if (wr_cnt_reg == CNT_W'(1)) begin
        for (int i = 0; i < PAGE_BYTES; i++) begin
          if (page_valid_reg[i]) begin
            mem[{page_base_reg, PAGE_W'(i)}] <= page_buf[i];
          end
        end
        page_valid_reg <= '0;
      end else if (start_ev && !busy) begin
        page_valid_reg <= '0;
      end else if (ack_entry && state_reg == SERA_ST_WDATA && !stop_ev && !start_ev) begin
        // A wrapped slot is simply overwritten by the later byte
        page_buf[addr_reg[PAGE_W-1:0]] <= shift_reg; // [RULE8]
        page_valid_reg[addr_reg[PAGE_W-1:0]] <= 1'b1;
        page_base_reg <= addr_reg[ADDR_W-1:PAGE_W];
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_reg;
  assign write_busy = busy;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence byte_in(sera_state_t st);
    ack_entry && state_reg == st && !start_ev && !stop_ev;
  endsequence
  sequence read_load;
    ack_exit && state_reg == SERA_ST_RDATA && mack_reg && !start_ev && !stop_ev;
  endsequence

  word_ack_a: assert property (byte_in(SERA_ST_WORD) |=> sda_oe) else $error("word address not acked"); // [RULE1]
  data_ack_a: assert property (byte_in(SERA_ST_WDATA) |=> sda_oe ##1 (sda_oe throughout (!ack_exit)[*1]))
    else $error("data byte not acked"); // [RULE2] [RULE6]
  busy_nack_a: assert property ((byte_in(SERA_ST_DEV) ##0 busy) |=> !sda_oe && state_reg == SERA_ST_IDLE)
    else $error("address acked while programming"); // [RULE3] [RULE9]
  timer_len_a: assert property ($rose(busy) |-> wr_cnt_reg == CNT_W'(WRITE_CYCLES))
    else $error("write timer bad length"); // [RULE4]
  page_wrap_a: assert property (byte_in(SERA_ST_WDATA) |=> addr_reg[ADDR_W-1:PAGE_W] == $past(addr_reg[ADDR_W-1:PAGE_W]))
    else $error("write address left its page"); // [RULE7]
  read_wrap_a: assert property (read_load and (##0 addr_reg == '1) |=> addr_reg == '0)
    else $error("read counter did not wrap"); // [RULE14] [RULE19]
  read_select_a: assert property (ack_exit && state_reg == SERA_ST_DEV && rw_reg && !start_ev && !stop_ev
    |=> state_reg == SERA_ST_RDATA && out_reg == $past(rd_byte)) else $error("read not started"); // [RULE10] [RULE15]
  ack_slot_a: assert property (sda_oe && state_reg != SERA_ST_RDATA |-> bit_cnt_reg == SERA_ACK_SLOT)
    else $error("line driven outside ack slot"); // [RULE11]
endmodule : sera_eeprom_core

// [dv/sera_ctrl_model.sv]
// Two-wire bus controller model: drives the serial clock and releases or pulls the data line
`timescale 1ns/100ps
module sera_ctrl_model import sera_pkg::*; (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_rel
);
  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  // Six clocks a half period gives the 48 ns link period and meets the target's minimum phase
  localparam int HALF = 6;

  // Clock stands high and data is released outside frames
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  // Data only moves mid-way through the low phase; the answer is read late in the high phase
  task automatic put_bit(input logic b, output logic seen);
    wait_clk(HALF / 2);
    sda_rel <= b;
    wait_clk(HALF / 2);
    scl <= 1'b1;
    wait_clk(HALF - 1);
    seen = sda_line;
    wait_clk(1);
    scl <= 1'b0;
  endtask : put_bit

  // ----------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------
  task automatic start_cond();
    wait_clk(HALF / 2);
    sda_rel <= 1'b1;
    wait_clk(HALF / 2);
    scl <= 1'b1;
    wait_clk(HALF);
    sda_rel <= 1'b0;
    wait_clk(HALF);
    scl <= 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    wait_clk(HALF / 2);
    sda_rel <= 1'b0;
    wait_clk(HALF / 2);
    scl <= 1'b1;
    wait_clk(HALF);
    sda_rel <= 1'b1;
    wait_clk(HALF);
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] d, output logic nack);
    logic unused;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], unused);
    end
    put_bit(1'b1, nack);
  endtask : send_byte

  // Last byte is left unacknowledged so the read can be closed by a stop
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic unused;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, d[i]);
    end
    put_bit(last, unused);
  endtask : get_byte
endmodule : sera_ctrl_model

// [dv/tb_top.sv]
// Self-checking bench for the two-wire serial memory target
`timescale 1ns/100ps
module tb_top import sera_pkg::*;;
  localparam int WC = 400;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [7:0] DEV_W = {SERA_DEV_CODE, STRAP, 1'b0};
  logic clk, reset, scl, sda_rel, sda_out, sda_oe, write_busy;
  wire sda_line;
  logic [7:0] mem_exp [256];
  logic [31:0] busy_len = 0;
  logic [31:0] last_len = 0;
  int miscompares = 0;
  int comparisons = 0;

  // Pull-up: a released line reads high
  assign sda_line = sda_rel & ~(sda_oe & ~sda_out);

  sera_eeprom_core #(.PAGE_ADDR_BITS(0), .PAGE_BYTES(8), .WRITE_CYCLES(WC)) sera_eeprom_core_inst (
    .clk(clk), .reset(reset), .clk_en(1'b1), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .strap_select_inputs(STRAP), .write_busy(write_busy));
  sera_ctrl_model sera_ctrl_model_inst (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (write_busy === 1'b1) busy_len <= busy_len + 1;
    else if (busy_len != 0) begin
      last_len <= busy_len;
      busy_len <= 0;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  // Polls until the target answers; a bounded number of tries
  task automatic open_dev(input logic rw, output int polls);
    logic nack;
    polls = 0;
    nack = 1'b1;
    while (nack === 1'b1) begin
      if (polls == 20) begin
        check("poll bound", polls, 0);
        final_report();
      end
      sera_ctrl_model_inst.start_cond();
      sera_ctrl_model_inst.send_byte({DEV_W[7:1], rw}, nack);
      if (nack === 1'b1) sera_ctrl_model_inst.stop_cond();
      polls++;
    end
  endtask : open_dev

  task automatic wr(input logic [7:0] addr, input int n, input logic [7:0] seed);
    logic nack;
    logic [7:0] a;
    int polls;
    open_dev(1'b0, polls);
    sera_ctrl_model_inst.send_byte(addr, nack);
    check("word ack", nack, 0);
    a = addr;
    for (int i = 0; i < n; i++) begin
      sera_ctrl_model_inst.send_byte(seed + i[7:0], nack);
      check("data ack", nack, 0);
      mem_exp[a] = seed + i[7:0];
      a = {a[7:3], a[2:0] + 3'h1};
    end
    sera_ctrl_model_inst.stop_cond();
    check("busy after stop", write_busy, 1);
  endtask : wr

  task automatic rd(input logic [7:0] addr, input int n, input logic random);
    logic nack;
    logic [7:0] got;
    int polls;
    if (random) begin
      open_dev(1'b0, polls);
      sera_ctrl_model_inst.send_byte(addr, nack);
      check("dummy ack", nack, 0);
    end
    open_dev(1'b1, polls);
    check("read polls", polls, 1);
    for (int i = 0; i < n; i++) begin
      sera_ctrl_model_inst.get_byte(i == n - 1, got);
      check("read data", got, mem_exp[addr + i[7:0]]);
    end
    sera_ctrl_model_inst.stop_cond();
  endtask : rd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_refuse();
    logic nack;
    logic [7:0] bad [2];
    bad[0] = {SERA_DEV_CODE, ~STRAP, 1'b0};
    bad[1] = {4'h5, STRAP, 1'b1};
    for (int k = 0; k < 2; k++) begin
      sera_ctrl_model_inst.start_cond();
      sera_ctrl_model_inst.send_byte(bad[k], nack);
      check("refused ack", nack, 1);
      sera_ctrl_model_inst.stop_cond();
    end
    $display("test refuse done");
  endtask : t_refuse

  // Ten bytes into an eight-byte page: the last two land on the first two written
  task automatic t_page();
    int polls;
    wr(8'h0e, 10, 8'h30);
    open_dev(1'b0, polls);
    check("nacked polls", polls > 1, 1);
    check("busy length", last_len, WC);
    sera_ctrl_model_inst.stop_cond();
    rd(8'h08, 7, 1'b1);
    rd(8'h0f, 1, 1'b0);
    $display("test page done");
  endtask : t_page

  task automatic t_wrap();
    wr(8'hfe, 2, 8'h5a);
    wr(8'h00, 1, 8'ha5);
    rd(8'hfe, 3, 1'b1);
    $display("test wrap done");
  endtask : t_wrap

  initial begin
    reset = 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    t_refuse();
    t_page();
    t_wrap();
    final_report();
  end

  initial begin
    repeat (100000) @(posedge clk);
    check("run time", 1, 0);
    final_report();
  end
endmodule : tb_top
